// ==== hw/crf_consts.svh ====
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH

// Register byte offsets on the APB slave
`define CRF_OFF_R0    7'h00
`define CRF_OFF_R1    7'h04
`define CRF_OFF_R2    7'h08
`define CRF_OFF_R3    7'h0C
`define CRF_OFF_A0    7'h10
`define CRF_OFF_A1    7'h14
`define CRF_OFF_FB    7'h18
`define CRF_OFF_INTERRUPT_TABLE_BASE  7'h1C
`define CRF_OFF_PC    7'h20
`define CRF_OFF_USP   7'h24
`define CRF_OFF_ISP   7'h28
`define CRF_OFF_SB    7'h2C
`define CRF_OFF_FLG   7'h30
`define CRF_OFF_SP    7'h34
`define CRF_OFF_W20   7'h38
`define CRF_OFF_W31   7'h3C
`define CRF_OFF_WA    7'h40
`define CRF_OFF_R0U   7'h44
`define CRF_OFF_R0B   7'h48
`define CRF_OFF_R1U   7'h4C
`define CRF_OFF_R1B   7'h50

// Flag register bit positions
`define CRF_FLG_CARRY 0
`define CRF_FLG_DEBUG 1
`define CRF_FLG_ZERO  2
`define CRF_FLG_SIGN  3
`define CRF_FLG_BANK  4
`define CRF_FLG_OVF   5
`define CRF_FLG_IEN   6
`define CRF_FLG_STACK 7

// Reset values
`define CRF_RST_W16   16'h0000
`define CRF_RST_W20   20'h0_0000
`define CRF_RST_FLG   11'h000

`endif

// ==== hw/crf_pkg.sv ====
package crf_pkg;
`include "crf_consts.svh"

	// Register selector, word index of each APB offset
	typedef enum logic [4:0] {
		CRF_SEL_R0   = 5'(`CRF_OFF_R0 >> 2),
		CRF_SEL_R1   = 5'(`CRF_OFF_R1 >> 2),
		CRF_SEL_R2   = 5'(`CRF_OFF_R2 >> 2),
		CRF_SEL_R3   = 5'(`CRF_OFF_R3 >> 2),
		CRF_SEL_A0   = 5'(`CRF_OFF_A0 >> 2),
		CRF_SEL_A1   = 5'(`CRF_OFF_A1 >> 2),
		CRF_SEL_FB   = 5'(`CRF_OFF_FB >> 2),
		CRF_SEL_INTERRUPT_TABLE_BASE = 5'(`CRF_OFF_INTERRUPT_TABLE_BASE >> 2),
		CRF_SEL_PC   = 5'(`CRF_OFF_PC >> 2),
		CRF_SEL_USP  = 5'(`CRF_OFF_USP >> 2),
		CRF_SEL_ISP  = 5'(`CRF_OFF_ISP >> 2),
		CRF_SEL_SB   = 5'(`CRF_OFF_SB >> 2),
		CRF_SEL_FLG  = 5'(`CRF_OFF_FLG >> 2),
		CRF_SEL_SP   = 5'(`CRF_OFF_SP >> 2),
		CRF_SEL_W20  = 5'(`CRF_OFF_W20 >> 2),
		CRF_SEL_W31  = 5'(`CRF_OFF_W31 >> 2),
		CRF_SEL_WA   = 5'(`CRF_OFF_WA >> 2),
		CRF_SEL_R0U  = 5'(`CRF_OFF_R0U >> 2),
		CRF_SEL_R0B  = 5'(`CRF_OFF_R0B >> 2),
		CRF_SEL_R1U  = 5'(`CRF_OFF_R1U >> 2),
		CRF_SEL_R1B  = 5'(`CRF_OFF_R1B >> 2)
	} crf_sel_e;

	typedef logic [15:0] crf_word_t;
	typedef logic [19:0] crf_addr_t;
	typedef logic [10:0] crf_flags_t;
endpackage

// ==== hw/crf_core_regs.sv ====
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "crf_consts.svh"

module crf_core_regs
	import crf_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core register write port
	input  wire logic        coreWrEn,
	input  wire logic [4:0]  coreWrSel,
	input  wire logic [31:0] coreWrData,
	// Core register read port
	input  wire logic [4:0]  coreRdSel,
	output logic      [31:0] coreRdData,
	// ALU flag update
	input  wire logic        aluFlagEn,
	input  wire logic        aluByte,
	input  wire logic [15:0] aluResult,
	input  wire logic        aluCarry,
	input  wire logic        aluOverflow,
	// Program counter control
	input  wire logic        pcLoad,
	input  wire logic [19:0] pcLoadValue,
	input  wire logic        pcAdvance,
	input  wire logic [2:0]  pcStep,
	// Stack pointer update
	input  wire logic        spWrEn,
	input  wire logic [15:0] spWrData,
	// Views for addressing and sequencing
	output logic      [19:0] programCounter,
	output logic      [15:0] stackPointer,
	output logic      [15:0] frameBase,
	output logic      [15:0] staticBase,
	output logic      [19:0] intTableBase,
	output logic      [15:0] addrReg0,
	output logic      [15:0] addrReg1,
	output logic      [10:0] flags
);

	// Banked registers: data, address and frame base
	crf_word_t  dataBank_q [2][4];
	crf_word_t  dataBank_d [2][4];
	crf_word_t  addrBank_q [2][2];
	crf_word_t  addrBank_d [2][2];
	crf_word_t  fbBank_q   [2];
	crf_word_t  fbBank_d   [2];
	// Common registers
	crf_addr_t  interrupt_table_base_q;
	crf_addr_t  interrupt_table_base_d;
	crf_addr_t  pc_q;
	crf_addr_t  pc_d;
	crf_word_t  usp_q;
	crf_word_t  usp_d;
	crf_word_t  isp_q;
	crf_word_t  isp_d;
	crf_word_t  sb_q;
	crf_word_t  sb_d;
	crf_flags_t flags_q;
	crf_flags_t flags_d;
	// Bus side
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] coreRd_q;
	logic [15:0] sp_q;
	logic [15:0] fbOut_q;
	logic [15:0] a0Out_q;
	logic [15:0] a1Out_q;
	logic        bank;
	logic        busAccess;
	logic        busCommit;
	logic [4:0]  busSel;
	logic        busMapped;
	logic        busReadOnly;
	logic        busFirst;
	logic        busErr;
	logic        stackSel;

	assign bank = flags_q[`CRF_FLG_BANK];

	// stack flag as held before the edge
	assign stackSel = flags_q[`CRF_FLG_STACK];

	// Bus decode; commit only at the edge that samples pready high
	assign busAccess   = psel & penable;
	assign busFirst    = busAccess & ~pready_q;
	assign busCommit   = busAccess & pready_q & pwrite & ~busErr;
	assign busSel      = paddr[6:2];
	assign busMapped   = isMapped(paddr);
	assign busReadOnly = (busSel == CRF_SEL_PC);
	// Unmapped, or a write to the read-only counter
	assign busErr      = ~busMapped | (pwrite & busReadOnly);

	// Address decode, used for bus accesses only; core reads are not checked
	function automatic logic isMapped(input logic [31:0] addr);
		isMapped = (addr[31:7] == 25'h000_0000) && (addr[1:0] == 2'b00)
			&& (addr[6:2] <= CRF_SEL_R1B);
	endfunction

	// Register read mux, used by the bus and the core port
	function automatic logic [31:0] readSel(input logic [4:0] sel);
		readSel = 32'h0000_0000;
		case (sel)
			CRF_SEL_R0, CRF_SEL_R1, CRF_SEL_R2, CRF_SEL_R3:
				readSel[15:0] = dataBank_q[bank][sel[1:0]];
			CRF_SEL_A0:   readSel[15:0] = addrBank_q[bank][0];
			CRF_SEL_A1:   readSel[15:0] = addrBank_q[bank][1];
			CRF_SEL_FB:   readSel[15:0] = fbBank_q[bank];
			CRF_SEL_INTERRUPT_TABLE_BASE: readSel[19:0] = interrupt_table_base_q;
			CRF_SEL_PC:   readSel[19:0] = pc_q;
			CRF_SEL_USP:  readSel[15:0] = usp_q;
			CRF_SEL_ISP:  readSel[15:0] = isp_q;
			CRF_SEL_SB:   readSel[15:0] = sb_q;
			CRF_SEL_FLG:  readSel[10:0] = flags_q;
			CRF_SEL_SP:   readSel[15:0] = stackSel ? isp_q : usp_q;
			CRF_SEL_W20:  readSel = {dataBank_q[bank][2], dataBank_q[bank][0]};
			CRF_SEL_W31:  readSel = {dataBank_q[bank][3], dataBank_q[bank][1]};
			CRF_SEL_WA:   readSel = {addrBank_q[bank][1], addrBank_q[bank][0]};
			CRF_SEL_R0U:  readSel[7:0] = dataBank_q[bank][0][15:8];
			CRF_SEL_R0B:  readSel[7:0] = dataBank_q[bank][0][7:0];
			CRF_SEL_R1U:  readSel[7:0] = dataBank_q[bank][1][15:8];
			CRF_SEL_R1B:  readSel[7:0] = dataBank_q[bank][1][7:0];
			default:      readSel = 32'h0000_0000;
		endcase
	endfunction

	// Next state of every register; bus write is applied last and wins
	always_comb
	begin
		logic        wrEn;
		logic [4:0]  wrSel;
		logic [31:0] wrData;
		wrEn     = 1'b0;
		wrSel    = 5'h00;
		wrData   = 32'h0000_0000;
		dataBank_d = dataBank_q;
		addrBank_d = addrBank_q;
		fbBank_d   = fbBank_q;
		interrupt_table_base_d     = interrupt_table_base_q;
		pc_d       = pc_q;
		usp_d      = usp_q;
		isp_d      = isp_q;
		sb_d       = sb_q;
		flags_d    = flags_q;
		if (pcLoad)
			pc_d = pcLoadValue;
		else if (pcAdvance)
			pc_d = pc_q + {17'h0_0000, pcStep};
		if (aluFlagEn)
		begin
			flags_d[`CRF_FLG_CARRY] = aluCarry;
			flags_d[`CRF_FLG_ZERO] = aluByte ? (aluResult[7:0] == 8'h00)
				: (aluResult == 16'h0000);
			flags_d[`CRF_FLG_SIGN] = aluByte ? aluResult[7] : aluResult[15];
			flags_d[`CRF_FLG_OVF] = aluOverflow;
		end
		// stack flag picks the pointer
		// A flag write in the same cycle steers only later pushes
		if (spWrEn)
		begin
			if (stackSel)
				isp_d = spWrData;
			else
				usp_d = spWrData;
		end
		// Core port first, then the bus
		for (int p = 0; p < 2; p++)
		begin
			wrEn   = (p == 0) ? coreWrEn : busCommit;
			wrSel  = (p == 0) ? coreWrSel : busSel;
			wrData = (p == 0) ? coreWrData : pwdata;
			if (wrEn)
			begin
				case (wrSel)
					CRF_SEL_R0, CRF_SEL_R1, CRF_SEL_R2, CRF_SEL_R3:
						dataBank_d[bank][wrSel[1:0]] = wrData[15:0];
					CRF_SEL_A0:   addrBank_d[bank][0] = wrData[15:0];
					CRF_SEL_A1:   addrBank_d[bank][1] = wrData[15:0];
					CRF_SEL_FB:   fbBank_d[bank] = wrData[15:0];
					CRF_SEL_INTERRUPT_TABLE_BASE: interrupt_table_base_d = wrData[19:0];
					CRF_SEL_PC:   pc_d = wrData[19:0];
					CRF_SEL_USP:  usp_d = wrData[15:0];
					CRF_SEL_ISP:  isp_d = wrData[15:0];
					CRF_SEL_SB:   sb_d = wrData[15:0];
					CRF_SEL_FLG:  flags_d = wrData[10:0];
					CRF_SEL_SP:
					begin
						if (stackSel)
							isp_d = wrData[15:0];
						else
							usp_d = wrData[15:0];
					end
					CRF_SEL_W20:
					begin
						dataBank_d[bank][0] = wrData[15:0];
						dataBank_d[bank][2] = wrData[31:16];
					end
					CRF_SEL_W31:
					begin
						dataBank_d[bank][1] = wrData[15:0];
						dataBank_d[bank][3] = wrData[31:16];
					end
					CRF_SEL_WA:
					begin
						addrBank_d[bank][0] = wrData[15:0];
						addrBank_d[bank][1] = wrData[31:16];
					end
					CRF_SEL_R0U:  dataBank_d[bank][0][15:8] = wrData[7:0];
					CRF_SEL_R0B:  dataBank_d[bank][0][7:0] = wrData[7:0];
					CRF_SEL_R1U:  dataBank_d[bank][1][15:8] = wrData[7:0];
					CRF_SEL_R1B:  dataBank_d[bank][1][7:0] = wrData[7:0];
					default:      ;
				endcase
			end
		end
	end

	// Register state; debug flag is stored as written, software keeps it 0
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int b = 0; b < 2; b++)
			begin
				for (int r = 0; r < 4; r++)
					dataBank_q[b][r] <= `CRF_RST_W16;
				addrBank_q[b][0] <= `CRF_RST_W16;
				addrBank_q[b][1] <= `CRF_RST_W16;
				fbBank_q[b]      <= `CRF_RST_W16;
			end
			interrupt_table_base_q  <= `CRF_RST_W20;
			pc_q    <= `CRF_RST_W20;
			usp_q   <= `CRF_RST_W16;
			isp_q   <= `CRF_RST_W16;
			sb_q    <= `CRF_RST_W16;
			flags_q <= `CRF_RST_FLG;
		end
		else
		begin
			dataBank_q <= dataBank_d;
			addrBank_q <= addrBank_d;
			fbBank_q   <= fbBank_d;
			interrupt_table_base_q     <= interrupt_table_base_d;
			pc_q       <= pc_d;
			usp_q      <= usp_d;
			isp_q      <= isp_d;
			sb_q       <= sb_d;
			flags_q    <= flags_d;
		end
	end

	// APB answer: one wait state so read data comes from a flop
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= busFirst;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			// First access cycle only; the answer then stands one cycle
			if (busFirst)
			begin
				if (busMapped && !pwrite)
					prdata_q <= readSel(busSel);
				pslverr_q <= busErr;
			end
		end
	end

	// Views taken from next values so they match state; core read port from current values
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			coreRd_q <= 32'h0000_0000;
			sp_q     <= `CRF_RST_W16;
			fbOut_q  <= `CRF_RST_W16;
			a0Out_q  <= `CRF_RST_W16;
			a1Out_q  <= `CRF_RST_W16;
		end
		else
		begin
			coreRd_q <= readSel(coreRdSel);
			sp_q     <= flags_d[`CRF_FLG_STACK] ? isp_d : usp_d;
			fbOut_q  <= fbBank_d[flags_d[`CRF_FLG_BANK]];
			a0Out_q  <= addrBank_d[flags_d[`CRF_FLG_BANK]][0];
			a1Out_q  <= addrBank_d[flags_d[`CRF_FLG_BANK]][1];
		end
	end

	// Output drive, all from flops
	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign coreRdData     = coreRd_q;
	assign programCounter = pc_q;
	assign stackPointer   = sp_q;
	assign frameBase      = fbOut_q;
	assign staticBase     = sb_q;
	assign intTableBase   = interrupt_table_base_q;
	assign addrReg0       = a0Out_q;
	assign addrReg1       = a1Out_q;
	assign flags          = flags_q;

endmodule // crf_core_regs

// ==== tb/crf_core_regs_asserts.sv ====
`timescale 1ns/1ps
module crf_core_regs_asserts
	import crf_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// Bus and core inputs
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        coreWrEn,
	input wire logic [4:0]  coreWrSel,
	input wire logic [31:0] coreWrData,
	input wire logic        aluFlagEn,
	input wire logic        aluByte,
	input wire logic [15:0] aluResult,
	input wire logic        aluCarry,
	input wire logic        aluOverflow,
	input wire logic        pcLoad,
	input wire logic [19:0] pcLoadValue,
	input wire logic        pcAdvance,
	input wire logic [2:0]  pcStep,
	// Register views
	input wire logic [19:0] programCounter,
	input wire logic [19:0] intTableBase,
	input wire logic [15:0] staticBase,
	input wire logic [15:0] addrReg0,
	input wire logic [15:0] addrReg1,
	input wire logic [10:0] flags
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// No core write and no bus access in flight, so nothing outranks the update
	logic quiet;
	assign quiet = !coreWrEn && !(psel && penable);
	sequence s_wait; psel && penable && !pready; endsequence
	sequence s_ans; pready ##1 !pready; endsequence
	sequence s_alu; aluFlagEn && quiet; endsequence
	sequence s_core(logic [4:0] s); coreWrEn && coreWrSel == s && !(psel && penable); endsequence
	AST_APB_ANSWER: assert property (s_wait |=> s_ans)
		else $error("bus answer not one wait");
	AST_APB_PHASE: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_PC_LOAD: assert property (pcLoad && quiet |=> programCounter == $past(pcLoadValue))
		else $error("counter load lost");
	AST_PC_STEP: assert property (pcAdvance && !pcLoad && quiet
		|=> programCounter == $past(programCounter) + 20'($past(pcStep)))
		else $error("counter step wrong");
	AST_CARRY: assert property (s_alu |=> flags[0] == $past(aluCarry))
		else $error("carry flag wrong");
	AST_ZERO: assert property (s_alu |=> flags[2] ==
		$past(aluByte ? aluResult[7:0] == 8'h00 : aluResult == 16'h0000))
		else $error("zero flag wrong");
	AST_SIGN: assert property (s_alu |=> flags[3] == $past(aluByte ? aluResult[7] : aluResult[15]))
		else $error("sign flag wrong");
	AST_OVF: assert property (s_alu |=> flags[5] == $past(aluOverflow))
		else $error("overflow flag wrong");
	AST_TABLE: assert property (s_core(5'h07) |=> intTableBase == $past(coreWrData[19:0]))
		else $error("table base write lost");
	AST_STATIC: assert property (s_core(5'h0B) |=> staticBase == $past(coreWrData[15:0]))
		else $error("static base write lost");
	AST_ADDR_PAIR: assert property (s_core(5'h10) |=> {addrReg1, addrReg0} == $past(coreWrData))
		else $error("address pair write wrong");
endmodule // crf_core_regs_asserts

bind crf_core_regs crf_core_regs_asserts u_chk (.ref_clk, .rst_b, .psel, .penable, .pready,
	.coreWrEn, .coreWrSel, .coreWrData, .aluFlagEn, .aluByte, .aluResult, .aluCarry,
	.aluOverflow, .pcLoad, .pcLoadValue, .pcAdvance, .pcStep, .programCounter,
	.intTableBase, .staticBase, .addrReg0, .addrReg1, .flags);

// ==== tb/crf_core_regs_tb_top.sv ====
`timescale 1ns/1ps
module crf_core_regs_tb_top;
	import crf_pkg::*;
	// Bench signals
	logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic        coreWrEn, aluFlagEn, aluByte, aluCarry, aluOverflow, pcLoad, pcAdvance, spWrEn;
	logic [31:0] paddr, pwdata, prdata, coreWrData, coreRdData, rd;
	logic [4:0]  coreWrSel, coreRdSel;
	logic [15:0] aluResult, spWrData, stackPointer, frameBase, staticBase, addrReg0, addrReg1;
	logic [19:0] pcLoadValue, programCounter, intTableBase;
	logic [2:0]  pcStep;
	logic [10:0] flags;
	int          nMismatch, testsRun;
	// Byte mode, result, carry, overflow; then expected flags
	logic [18:0] aluIn [4] = '{19'h0_0002, 19'h2_0001, 19'h4_0400, 19'h4_0203};
	logic [10:0] aluExp [4] = '{11'h005, 11'h028, 11'h004, 11'h029};

	crf_core_regs u_dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .coreWrEn, .coreWrSel, .coreWrData, .coreRdSel, .coreRdData,
		.aluFlagEn, .aluByte, .aluResult, .aluCarry, .aluOverflow, .pcLoad, .pcLoadValue,
		.pcAdvance, .pcStep, .spWrEn, .spWrData, .programCounter, .stackPointer, .frameBase,
		.staticBase, .intTableBase, .addrReg0, .addrReg1, .flags);

	// Clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] seen, exp);
		testsRun++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One bus transfer; waits for ready, not for a fixed count
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never gets an answer
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input logic [31:0] a, exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask

	task automatic coreWr(input logic [4:0] s, input logic [31:0] d);
		@(posedge ref_clk);
		coreWrEn <= 1'b1;
		coreWrSel <= s;
		coreWrData <= d;
		@(posedge ref_clk);
		coreWrEn <= 1'b0;
		@(negedge ref_clk);
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rst_b, psel, penable, pwrite, paddr, pwdata, coreWrEn, coreWrSel, coreWrData} = '0;
		{coreRdSel, aluFlagEn, aluByte, aluResult, aluCarry, aluOverflow} = '0;
		{pcLoad, pcLoadValue, pcAdvance, pcStep, spWrEn, spWrData} = '0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 13; i++) rdChk(32'(4 * i), 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 12; i++)
			if (i != 8)
			begin
				apb(1'b1, 32'(4 * i), 32'hFFFF_FFFF);
				rdChk(32'(4 * i), i == 7 ? 32'h000F_FFFF : 32'h0000_FFFF);
			end
		check({frameBase, staticBase}, 32'hFFFF_FFFF);
		check({addrReg1, stackPointer}, 32'hFFFF_FFFF);
		check({12'h000, intTableBase}, 32'h000F_FFFF);
		$display("test width done");
		for (int k = 0; k < 2; k++)
		begin
			apb(1'b1, 32'(4 * k), 32'h0000_1234);
			apb(1'b1, 32'(68 + 8 * k), 32'h0000_00AB);
			rdChk(32'(4 * k), 32'h0000_AB34);
			apb(1'b1, 32'(72 + 8 * k), 32'h0000_00CD);
			rdChk(32'(4 * k), 32'h0000_ABCD);
			rdChk(32'(68 + 8 * k), 32'h0000_00AB);
		end
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, 32'(56 + 4 * k), 32'h1357_2468 + 32'(k));
			rdChk(k < 2 ? 32'(8 + 4 * k) : 32'h0000_0014, 32'h0000_1357);
			rdChk(k < 2 ? 32'(4 * k) : 32'h0000_0010, 32'h0000_2468 + 32'(k));
		end
		check({addrReg1, addrReg0}, 32'h1357_246A);
		$display("test split done");
		apb(1'b1, 32'h0000_0000, 32'h0000_0055);
		apb(1'b1, 32'h0000_0030, 32'h0000_0010);
		rdChk(32'h0000_0000, 32'h0000_0000);
		apb(1'b1, 32'h0000_0000, 32'h0000_00AA);
		apb(1'b1, 32'h0000_0030, 32'h0000_0000);
		rdChk(32'h0000_0000, 32'h0000_0055);
		apb(1'b1, 32'h0000_0024, 32'h0000_1000);
		apb(1'b1, 32'h0000_0028, 32'h0000_2000);
		rdChk(32'h0000_0034, 32'h0000_1000);
		apb(1'b1, 32'h0000_0030, 32'h0000_0080);
		rdChk(32'h0000_0034, 32'h0000_2000);
		@(posedge ref_clk);
		spWrEn <= 1'b1;
		spWrData <= 16'h2222;
		@(posedge ref_clk);
		spWrEn <= 1'b0;
		@(negedge ref_clk);
		check({16'h0000, stackPointer}, 32'h0000_2222);
		rdChk(32'h0000_0024, 32'h0000_1000);
		apb(1'b1, 32'h0000_0030, 32'h0000_0000);
		$display("test bank done");
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			aluFlagEn <= 1'b1;
			{aluByte, aluResult, aluCarry, aluOverflow} <= aluIn[i];
			@(posedge ref_clk);
			aluFlagEn <= 1'b0;
			@(negedge ref_clk);
			check({21'h00_0000, flags}, {21'h00_0000, aluExp[i]});
		end
		check({31'h0000_0000, flags[1]}, 32'h0000_0000);
		$display("test flags done");
		@(posedge ref_clk);
		pcLoad <= 1'b1;
		pcLoadValue <= 20'hF_FFFE;
		@(posedge ref_clk);
		pcLoad <= 1'b0;
		pcAdvance <= 1'b1;
		pcStep <= 3'h3;
		@(posedge ref_clk);
		pcAdvance <= 1'b0;
		@(negedge ref_clk);
		check({12'h000, programCounter}, 32'h0000_0001);
		apb(1'b1, 32'h0000_0020, 32'h0000_0005);
		check({31'h0000_0000, err}, 32'h0000_0001);
		rdChk(32'h0000_0020, 32'h0000_0001);
		rdChk(32'h0000_0054, 32'h0000_0000);
		check({31'h0000_0000, err}, 32'h0000_0001);
		$display("test counter done");
		coreWr(5'h07, 32'h000A_BCDE);
		check({12'h000, intTableBase}, 32'h000A_BCDE);
		coreWr(5'h0B, 32'h0000_4321);
		coreWr(5'h10, 32'h1111_2222);
		check({addrReg1, addrReg0}, 32'h1111_2222);
		@(posedge ref_clk);
		coreRdSel <= 5'h0B;
		@(posedge ref_clk);
		@(negedge ref_clk);
		check(coreRdData, 32'h0000_4321);
		$display("test core done");
		results();
	end

	// Watchdog
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		nMismatch++;
		results();
	end
endmodule // crf_core_regs_tb_top
